// file: src/pmw_pkg.sv
// Package: constants and carriers for the power management register bank
package pmw_pkg;

  // Register byte offsets within the capability structure
  localparam logic [7:0] PMW_CAP_OFFSET = 8'h02;
  localparam logic [7:0] PMW_CSR_OFFSET = 8'h04;

  // Capability word fields
  localparam logic [2:0] PMW_PM_VERSION = 3'h2;
  localparam logic [4:0] PMW_PME_SUPPORT_NOAUX = 5'h09;
  localparam logic [4:0] PMW_PME_SUPPORT_AUX = 5'h19;
  localparam int PMW_CAP_SUPPORT_LSB = 11;
  localparam int PMW_CAP_LIGHT_SLEEP_BIT = 9;
  localparam int PMW_CAP_DSI_BIT = 5;
  localparam int PMW_CAP_PME_CLOCK_BIT = 3;

  // Control/status word fields
  localparam int PMW_CSR_STATUS_BIT = 15;
  localparam int PMW_CSR_SCALE_LSB = 13;
  localparam int PMW_CSR_SELECT_LSB = 9;
  localparam int PMW_CSR_ENABLE_BIT = 8;
  localparam int PMW_CSR_STATE_LSB = 0;

  // Power state encodings
  localparam logic [1:0] PMW_STATE_D0 = 2'h0;
  localparam logic [1:0] PMW_STATE_D3 = 2'h3;

  // Data scale values
  localparam logic [1:0] PMW_SCALE_TENTH_WATT = 2'h1;
  localparam logic [1:0] PMW_SCALE_UNKNOWN = 2'h0;

  // Reset values
  localparam logic [3:0] PMW_SELECT_RESET = 4'h0;
  localparam logic [15:0] PMW_RDATA_RESET = 16'h0000;

  // One configuration access, taken in a single cycle
  typedef struct packed {
    logic valid;
    logic we;
    logic [7:0] addr;
    logic [1:0] be;
    logic [15:0] wdata;
  } pmw_cfg_req_s;

  // Settings loaded from the configuration EEPROM
  typedef struct packed {
    logic loaded;
    logic pm_enable;
    logic pme_clock;
    logic manageability;
  } pmw_ee_cfg_s;

endpackage

// file: src/pmw_rise.sv
// Rising edge detector for a synchronous level input
`timescale 1ns/100ps
module pmw_rise (
  input wire logic mclk,
  input wire logic reset,
  input wire logic level,
  output logic rise
);
  logic prev;
  logic next_prev;

  always_comb begin
    next_prev = level;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      prev <= 1'b1;
    end else begin
      prev <= next_prev;
    end
  end

  assign rise = level & ~prev;
endmodule

// file: src/pmw_flag.sv
// Sticky flag: set wins over software clear, hard clear wins over all
`timescale 1ns/100ps
module pmw_flag (
  input wire logic mclk,
  input wire logic reset,
  input wire logic set,
  input wire logic sw_clr,
  input wire logic hard_clr,
  output logic q
);
  logic next_q;

  always_comb begin
    if (hard_clr) begin
      next_q = 1'b0;
    end else begin
      next_q = set | (q & ~sw_clr);
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      q <= 1'b0;
    end else begin
      q <= next_q;
    end
  end
endmodule

// file: src/pmw_csr.sv
// Power management capability and control/status register bank
`timescale 1ns/100ps
module pmw_csr (
  input wire logic mclk,
  input wire logic reset,
  input pmw_pkg::pmw_cfg_req_s cfg_req,
  output logic cfg_ack,
  output logic [15:0] cfg_rdata,
  input pmw_pkg::pmw_ee_cfg_s ee_cfg,
  input wire logic aux_power,
  input wire logic standby_supply_good,
  input wire logic pci_rst_n,
  input wire logic wake_event,
  input wire logic magic_event,
  input wire logic legacy_magic_wake,
  output logic pme_n_out,
  output logic pme_oe,
  output logic [1:0] current_power_state,
  output logic [1:0] data_scale,
  output logic [3:0] data_select,
  output logic wake_enable,
  output logic wake_status
);
  import pmw_pkg::*;

  logic pci_rise;
  logic hard_clr;
  logic wr_csr;
  logic rd_cap;
  logic rd_csr;
  logic status_clr;
  logic status_set;
  logic legacy_set;
  logic legacy_hold;
  logic status_q;
  logic [15:0] cap_word;
  logic [15:0] csr_word;
  logic [1:0] scale_now;

  logic next_ack;
  logic [15:0] next_rdata;
  logic [1:0] next_state;
  logic [3:0] next_select;
  logic next_enable;
  logic next_pme_oe;
  logic [1:0] next_scale;
  logic next_status_out;

  // Trailing edge of the PCI reset
  pmw_rise u_rst_edge (
    .mclk(mclk),
    .reset(reset),
    .level(pci_rst_n),
    .rise(pci_rise)
  );

  // Loss of standby power always clears; PCI reset only without aux
  assign hard_clr = ~standby_supply_good | (pci_rise & ~aux_power);

  assign wr_csr = cfg_req.valid & cfg_req.we
    & (cfg_req.addr == PMW_CSR_OFFSET);
  assign rd_cap = cfg_req.valid & ~cfg_req.we
    & (cfg_req.addr == PMW_CAP_OFFSET);
  assign rd_csr = cfg_req.valid & ~cfg_req.we
    & (cfg_req.addr == PMW_CSR_OFFSET);

  assign status_clr = wr_csr & cfg_req.be[1]
    & cfg_req.wdata[PMW_CSR_STATUS_BIT];
  assign status_set = wake_event
    | (magic_event & legacy_magic_wake);
  assign legacy_set = magic_event & legacy_magic_wake;

  // Wake status flag
  pmw_flag u_status (
    .mclk(mclk),
    .reset(reset),
    .set(status_set),
    .sw_clr(status_clr),
    .hard_clr(hard_clr),
    .q(status_q)
  );

  // Legacy wake hold, ends with status clear or legacy mode off
  pmw_flag u_legacy (
    .mclk(mclk),
    .reset(reset),
    .set(legacy_set),
    .sw_clr(status_clr),
    .hard_clr(hard_clr | ~legacy_magic_wake),
    .q(legacy_hold)
  );

  // Data scale from manageability and selected data item
  always_comb begin
    scale_now = PMW_SCALE_UNKNOWN;
    if (ee_cfg.manageability) begin
      case (data_select)
        4'h0, 4'h3, 4'h4, 4'h7: begin
          scale_now = PMW_SCALE_TENTH_WATT;
        end
        default: begin
          scale_now = PMW_SCALE_UNKNOWN;
        end
      endcase
    end
  end

  // Read words
  always_comb begin
    cap_word = 16'h0000;
    if (ee_cfg.pm_enable) begin
      cap_word[PMW_CAP_SUPPORT_LSB +: 5] = aux_power ?
        PMW_PME_SUPPORT_AUX : PMW_PME_SUPPORT_NOAUX;
    end
    cap_word[PMW_CAP_LIGHT_SLEEP_BIT] = 1'b0;
    cap_word[8:6] = 3'h0;
    cap_word[PMW_CAP_DSI_BIT] = 1'b1;
    cap_word[PMW_CAP_PME_CLOCK_BIT] = ee_cfg.loaded
      & ee_cfg.pme_clock;
    cap_word[2:0] = PMW_PM_VERSION;
    csr_word = 16'h0000;
    csr_word[PMW_CSR_STATUS_BIT] = status_q;
    csr_word[PMW_CSR_SCALE_LSB +: 2] = scale_now;
    csr_word[PMW_CSR_SELECT_LSB +: 4] = data_select;
    csr_word[PMW_CSR_ENABLE_BIT] = wake_enable;
    csr_word[PMW_CSR_STATE_LSB +: 2] = current_power_state;
  end

  // Register next values
  always_comb begin
    next_ack = cfg_req.valid;
    next_rdata = PMW_RDATA_RESET;
    if (rd_cap) begin
      next_rdata = cap_word;
    end else if (rd_csr) begin
      next_rdata = csr_word;
    end
    next_state = current_power_state;
    if (pci_rise) begin
      next_state = PMW_STATE_D0;
    end else if (wr_csr && cfg_req.be[0] && ee_cfg.pm_enable
        && (cfg_req.wdata[1:0] == PMW_STATE_D0
        || cfg_req.wdata[1:0] == PMW_STATE_D3)) begin
      next_state = cfg_req.wdata[1:0];
    end
    next_select = data_select;
    if (wr_csr && cfg_req.be[1] && ee_cfg.pm_enable) begin
      next_select = cfg_req.wdata[PMW_CSR_SELECT_LSB +: 4];
    end
    next_enable = wake_enable;
    if (hard_clr) begin
      next_enable = 1'b0;
    end else if (wr_csr && cfg_req.be[1]) begin
      next_enable = cfg_req.wdata[PMW_CSR_ENABLE_BIT]
        & ee_cfg.pm_enable;
    end
    next_pme_oe = (status_q & wake_enable) | legacy_hold;
    next_scale = scale_now;
    next_status_out = status_q;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      cfg_ack <= 1'b0;
      cfg_rdata <= PMW_RDATA_RESET;
      current_power_state <= PMW_STATE_D0;
      data_select <= PMW_SELECT_RESET;
      wake_enable <= 1'b0;
      pme_oe <= 1'b0;
      pme_n_out <= 1'b0;
      data_scale <= PMW_SCALE_UNKNOWN;
      wake_status <= 1'b0;
    end else begin
      cfg_ack <= next_ack;
      cfg_rdata <= next_rdata;
      current_power_state <= next_state;
      data_select <= next_select;
      wake_enable <= next_enable;
      pme_oe <= next_pme_oe;
      pme_n_out <= 1'b0;
      data_scale <= next_scale;
      wake_status <= next_status_out;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  light_sleep_zero_a: assert property (
    rd_cap |=> cfg_rdata[PMW_CAP_LIGHT_SLEEP_BIT] == 1'b0
      && cfg_rdata[PMW_CAP_DSI_BIT] == 1'b1)
    else $error("capability flags wrong");

  cap_fixed_fields_a: assert property (
    rd_cap |=> cfg_rdata[8:6] == 3'h0 && cfg_rdata[2:0] == PMW_PM_VERSION)
    else $error("capability fixed fields wrong");

  pme_clock_load_a: assert property (
    rd_cap && !ee_cfg.loaded |=> !cfg_rdata[PMW_CAP_PME_CLOCK_BIT])
    else $error("clock flag set without load");

  status_sets_a: assert property (
    status_set && !hard_clr |=> status_q ##1 wake_status)
    else $error("wake status not set");

  status_clear_a: assert property (
    status_q && status_clr && !status_set && !legacy_set
      && !legacy_hold |=> !status_q ##1 !pme_oe)
    else $error("wake status clear failed");

  aux_keeps_a: assert property (
    pci_rise && aux_power && standby_supply_good && wake_enable
      && !wr_csr |=> wake_enable)
    else $error("wake enable lost under aux power");

  scale_value_a: assert property (
    ee_cfg.manageability && data_select == 4'h3
      && $stable(data_select) |=> data_scale == PMW_SCALE_TENTH_WATT)
    else $error("data scale wrong");

  enable_blocked_a: assert property (
    !ee_cfg.pm_enable && !wake_enable |=> !wake_enable)
    else $error("wake enable set while disabled");

  state_discard_a: assert property (
    wr_csr && !pci_rise && (cfg_req.wdata[1:0] == 2'h1
      || cfg_req.wdata[1:0] == 2'h2)
      |=> $stable(current_power_state))
    else $error("unsupported state accepted");

  reset_edge_d0_a: assert property (
    pci_rise |=> current_power_state == PMW_STATE_D0)
    else $error("power state not D0 after reset edge");

  reserved_zero_a: assert property (
    rd_csr |=> cfg_rdata[7:2] == 6'h00)
    else $error("reserved bits not zero");

  pme_follows_a: assert property (
    status_q && wake_enable ##1 status_q && wake_enable |-> pme_oe)
    else $error("PME not asserted");

  pme_clock_copy_a: assert property (
    rd_cap && ee_cfg.loaded && ee_cfg.pme_clock
      |=> cfg_rdata[PMW_CAP_PME_CLOCK_BIT])
    else $error("clock flag not loaded");

  supply_loss_clr_a: assert property (
    !standby_supply_good |=> !status_q && !wake_enable)
    else $error("supply loss did not clear wake flags");

  reset_noaux_clr_a: assert property (
    pci_rise && !aux_power |=> !status_q && !wake_enable)
    else $error("reset edge did not clear wake flags");

  scale_unknown_a: assert property (
    !ee_cfg.manageability |=> data_scale == PMW_SCALE_UNKNOWN)
    else $error("data scale set without manageability");

  select_locked_a: assert property (
    !ee_cfg.pm_enable |=> $stable(data_select))
    else $error("data select written while disabled");

  state_write_a: assert property (
    wr_csr && cfg_req.be[0] && ee_cfg.pm_enable && !pci_rise
      && cfg_req.wdata[1:0] == PMW_STATE_D3
      |=> current_power_state == PMW_STATE_D3)
    else $error("D3 write not taken");

  state_locked_a: assert property (
    !ee_cfg.pm_enable && !pci_rise |=> $stable(current_power_state))
    else $error("power state changed while disabled");

  legacy_pme_a: assert property (
    legacy_set && !hard_clr |-> ##2 pme_oe)
    else $error("legacy wake did not assert PME");

  csr_answer_a: assert property (
    rd_csr |=> cfg_ack)
    else $error("control word read not answered");

  state_readback_a: assert property (
    rd_csr |=> cfg_rdata[1:0] == $past(current_power_state))
    else $error("power state read back wrong");

  pme_low_a: assert property (
    pme_oe |-> !pme_n_out)
    else $error("PME driven high");
endmodule

// file: sim/pmw_host.sv
// Configuration host model issuing single-cycle register accesses
`timescale 1ns/100ps
module pmw_host (
  input wire logic mclk,
  output pmw_pkg::pmw_cfg_req_s cfg_req
);
  import pmw_pkg::*;
  logic [15:0] exp_q[$];
  initial cfg_req = '0;
  // One strobe cycle, then one idle cycle so no edge gets two drives
  task automatic access(input logic we, input logic [7:0] addr,
                        input logic [15:0] wdata, input logic [15:0] exp);
    @(posedge mclk);
    cfg_req <= '{1'b1, we, addr, 2'h3, wdata};
    exp_q.push_back(exp);
    @(posedge mclk);
    cfg_req <= '0;
  endtask
endmodule

// file: sim/pmw_csr_tb.sv
// Self-checking testbench for the power management register bank
`timescale 1ns/100ps
module pmw_csr_tb;
  import pmw_pkg::*;
  logic mclk, reset, cfg_ack, pme_n_out, pme_oe, wake_enable, wake_status;
  logic aux_power, standby_supply_good, pci_rst_n, wake_event, magic_event;
  logic legacy_magic_wake, pme_wire_n;
  logic [15:0] cfg_rdata, got;
  logic [1:0] current_power_state, data_scale, sc;
  logic [3:0] data_select;
  logic [31:0] r;
  pmw_cfg_req_s cfg_req;
  pmw_ee_cfg_s ee;
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;
  integer seed = 32'h77a2;

  // PME wire with its pull-up
  assign pme_wire_n = pme_oe ? pme_n_out : 1'b1;

  pmw_host pmw_host_inst (.mclk(mclk), .cfg_req(cfg_req));
  pmw_csr pmw_csr_inst (
    .mclk(mclk), .reset(reset), .cfg_req(cfg_req), .cfg_ack(cfg_ack),
    .cfg_rdata(cfg_rdata), .ee_cfg(ee), .aux_power(aux_power),
    .standby_supply_good(standby_supply_good), .pci_rst_n(pci_rst_n),
    .wake_event(wake_event), .magic_event(magic_event),
    .legacy_magic_wake(legacy_magic_wake), .pme_n_out(pme_n_out),
    .pme_oe(pme_oe), .current_power_state(current_power_state),
    .data_scale(data_scale), .data_select(data_select),
    .wake_enable(wake_enable), .wake_status(wake_status)
  );

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic tally_and_finish;
    if (mismatches == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic cmp_word(input logic [15:0] a, input logic [15:0] e);
    n_checks++;
    if (a !== e) begin
      mismatches++;
      $display("BAD %0t read %h expected %h", $time, a, e);
    end
  endtask

  task automatic chk(input logic a, input logic e);
    n_checks++;
    if (a !== e) begin
      mismatches++;
      $display("BAD %0t flag %b expected %b", $time, a, e);
    end
  endtask

  task automatic rd(input logic [7:0] addr, input logic [15:0] e);
    pmw_host_inst.access(1'b0, addr, 16'h0000, e);
  endtask

  task automatic wr(input logic [15:0] d);
    pmw_host_inst.access(1'b1, PMW_CSR_OFFSET, d, 16'h0000);
  endtask

  task automatic settle;
    repeat (3) @(posedge mclk);
    #1;
  endtask

  task automatic pulse(input logic magic);
    @(posedge mclk);
    if (magic) begin
      magic_event <= 1'b1;
    end else begin
      wake_event <= 1'b1;
    end
    @(posedge mclk);
    magic_event <= 1'b0;
    wake_event <= 1'b0;
    settle;
  endtask

  task automatic pci_reset;
    @(posedge mclk);
    pci_rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    pci_rst_n <= 1'b1;
    settle;
  endtask

  // Result monitor: every ack retires the oldest expected word
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cfg_ack === 1'b1) begin
      if (pmw_host_inst.exp_q.size() == 0) begin
        mismatches++;
        $display("BAD %0t ack without request", $time);
      end else begin
        got = pmw_host_inst.exp_q.pop_front();
        cmp_word(cfg_rdata, got);
      end
    end
    if (cycles == 3000) begin
      mismatches++;
      tally_and_finish;
    end
  end

  initial begin
    reset = 1'b1;
    ee = 4'hf;
    aux_power = 1'b0;
    standby_supply_good = 1'b1;
    pci_rst_n = 1'b1;
    wake_event = 1'b0;
    magic_event = 1'b0;
    legacy_magic_wake = 1'b0;
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    rd(PMW_CAP_OFFSET, 16'h482a);
    rd(PMW_CSR_OFFSET, 16'h2000);
    for (int s = 0; s < 16; s++) begin
      r = $random(seed);
      sc = (s inside {0, 3, 4, 7}) ? 2'h1 : 2'h0;
      wr({1'b0, r[14:13], s[3:0], 1'b1, r[7:2], 2'h3});
      rd(PMW_CSR_OFFSET, {1'b0, sc, s[3:0], 9'h103});
      chk(data_select == s[3:0], 1'b1);
      chk(data_scale == sc, 1'b1);
      chk(current_power_state == PMW_STATE_D3, 1'b1);
      chk(wake_enable, 1'b1);
    end
    wr(16'h0101);
    rd(PMW_CSR_OFFSET, 16'h2103);
    wr(16'h0102);
    rd(PMW_CSR_OFFSET, 16'h2103);
    pulse(1'b0);
    chk(pme_wire_n, 1'b0);
    chk(wake_status, 1'b1);
    wr(16'h0103);
    rd(PMW_CSR_OFFSET, 16'ha103);
    wr(16'h8103);
    settle;
    chk(pme_wire_n, 1'b1);
    rd(PMW_CSR_OFFSET, 16'h2103);
    wr(16'h0003);
    pulse(1'b0);
    chk(pme_wire_n, 1'b1);
    rd(PMW_CSR_OFFSET, 16'ha003);
    wr(16'h8003);
    legacy_magic_wake <= 1'b1;
    pulse(1'b1);
    chk(pme_wire_n, 1'b0);
    wr(16'h8003);
    legacy_magic_wake <= 1'b0;
    settle;
    chk(pme_wire_n, 1'b1);
    wr(16'h0103);
    pulse(1'b0);
    pci_reset;
    rd(PMW_CSR_OFFSET, 16'h2000);
    @(posedge mclk);
    aux_power <= 1'b1;
    wr(16'h0103);
    pulse(1'b0);
    pci_reset;
    rd(PMW_CSR_OFFSET, 16'ha100);
    rd(PMW_CAP_OFFSET, 16'hc82a);
    @(posedge mclk);
    standby_supply_good <= 1'b0;
    @(posedge mclk);
    standby_supply_good <= 1'b1;
    settle;
    rd(PMW_CSR_OFFSET, 16'h2000);
    @(posedge mclk);
    ee.pm_enable <= 1'b0;
    wr(16'h0b03);
    rd(PMW_CSR_OFFSET, 16'h2000);
    rd(PMW_CAP_OFFSET, 16'h002a);
    ee.loaded <= 1'b0;
    rd(PMW_CAP_OFFSET, 16'h0022);
    ee.manageability <= 1'b0;
    rd(PMW_CSR_OFFSET, 16'h0000);
    chk(data_scale == PMW_SCALE_UNKNOWN, 1'b1);
    ee <= 4'hf;
    wr(16'h0100);
    reset <= 1'b1;
    @(posedge mclk);
    reset <= 1'b0;
    rd(PMW_CSR_OFFSET, 16'h2000);
    settle;
    if (pmw_host_inst.exp_q.size() != 0) begin
      mismatches++;
      $display("BAD %0t answer missing", $time);
    end
    tally_and_finish;
  end
endmodule
